// File: common/ppm_consts.svh
// Register offsets, reset values and field positions of the port pin function mux.
`ifndef PPM_CONSTS_SVH
`define PPM_CONSTS_SVH
`define PPM_ADDR_W        6
`define PPM_P1_IN         6'h00
`define PPM_P1_OUT        6'h01
`define PPM_P1_DIR        6'h02
`define PPM_P1_IFG        6'h03
`define PPM_P1_IES        6'h04
`define PPM_P1_IE         6'h05
`define PPM_P1_SEL        6'h06
`define PPM_P2_IN         6'h08
`define PPM_P2_OUT        6'h09
`define PPM_P2_DIR        6'h0A
`define PPM_P2_IFG        6'h0B
`define PPM_P2_IES        6'h0C
`define PPM_P2_IE         6'h0D
`define PPM_P2_SEL        6'h0E
`define PPM_P3_IN         6'h10
`define PPM_P3_OUT        6'h11
`define PPM_P3_DIR        6'h12
`define PPM_P3_SEL        6'h13
`define PPM_RST_BYTE      8'h00
`define PPM_P2_PAD_MASK   8'h3F
`define PPM_P2_ROSC_BIT   5
`define PPM_P3_STE_BIT    0
`endif

// File: common/ppm_pkg.sv
// Types of the port pin function mux.
package ppm_pkg;
  typedef logic [7:0] ppm_byte_t;
  typedef struct packed {
    ppm_byte_t p1Out;
    ppm_byte_t p1Dir;
    ppm_byte_t p1Sel;
    ppm_byte_t p1Ie;
    ppm_byte_t p1Ifg;
    ppm_byte_t p1Ies;
    ppm_byte_t p1InPrev;
    ppm_byte_t p2Out;
    ppm_byte_t p2Dir;
    ppm_byte_t p2Sel;
    ppm_byte_t p2Ie;
    ppm_byte_t p2Ifg;
    ppm_byte_t p2Ies;
    ppm_byte_t p2InPrev;
    ppm_byte_t p3Out;
    ppm_byte_t p3Dir;
    ppm_byte_t p3Sel;
    ppm_byte_t padOut;
    ppm_byte_t padOe;
    ppm_byte_t pad2Out;
    ppm_byte_t pad2Oe;
    ppm_byte_t pad3Out;
    ppm_byte_t pad3Oe;
    ppm_byte_t rdData;
    logic      irq1;
    logic      irq2;
    logic      tmrExtClk;
    logic      tmrAltClk;
    logic [2:0] capA;
    logic [1:0] capB;
    logic      slaveTxEn;
  } ppm_state_t;
endpackage

// File: design/ppm_port_pin_function_mux.sv
// Pin function multiplexer for three 8-bit ports with port one and two edge interrupts.
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/100ps
`include "ppm_consts.svh"
module ppm_port_pin_function_mux
  import ppm_pkg::*;
#(
  parameter int PORT_W = 8
)(
  input  wire logic                   clk,
  input  wire logic                   rstn,
  input  wire logic [`PPM_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]             regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [7:0]             regRdData,
  input  wire logic [7:0]             p1PadIn,
  output logic      [7:0]             p1PadOut,
  output logic      [7:0]             p1PadOe,
  input  wire logic [7:0]             p2PadIn,
  output logic      [7:0]             p2PadOut,
  output logic      [7:0]             p2PadOe,
  input  wire logic [7:0]             p3PadIn,
  output logic      [7:0]             p3PadOut,
  output logic      [7:0]             p3PadOe,
  input  wire logic                   converterClock,
  input  wire logic                   subsystemClock,
  input  wire logic                   auxClock,
  input  wire logic                   timerOutputUnit0,
  input  wire logic                   timerOutputUnit1,
  input  wire logic                   timerOutputUnit2,
  input  wire logic                   extResistorSelect,
  output logic                        timerExternalClock,
  output logic                        timerAlternateClock,
  output logic      [2:0]             captureInputA,
  output logic      [1:0]             captureInputB,
  output logic                        serialSlaveTransmitEnable,
  output logic                        p1Irq,
  output logic                        p2Irq
);

  // The pin maps below are fixed to eight pins a port; refuse any other width.
  if (PORT_W != 8)
  begin : g_width_check
    $error("PORT_W must be 8");
  end

  // Two-stage synchronisers for every asynchronous pin and the resistor select.
  logic [7:0] p1Meta_r;
  logic [7:0] p1Sync_r;
  logic [7:0] p2Meta_r;
  logic [7:0] p2Sync_r;
  logic [7:0] p3Meta_r;
  logic [7:0] p3Sync_r;
  logic       rselMeta_r;
  logic       rselSync_r;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      p1Meta_r   <= 8'h00;
      p1Sync_r   <= 8'h00;
      p2Meta_r   <= 8'h00;
      p2Sync_r   <= 8'h00;
      p3Meta_r   <= 8'h00;
      p3Sync_r   <= 8'h00;
      rselMeta_r <= 1'b0;
      rselSync_r <= 1'b0;
    end
    else
    begin
      p1Meta_r   <= p1PadIn;
      p1Sync_r   <= p1Meta_r;
      p2Meta_r   <= p2PadIn;
      p2Sync_r   <= p2Meta_r;
      p3Meta_r   <= p3PadIn;
      p3Sync_r   <= p3Meta_r;
      rselMeta_r <= extResistorSelect;
      rselSync_r <= rselMeta_r;
    end
  end

  // Edge detect on one pin: edge select 0 picks rising, 1 picks falling.
  function automatic logic pinEdge(
    input logic now,
    input logic prev,
    input logic ies
  );
    pinEdge = ies ? (prev & ~now) : (now & ~prev);
  endfunction

  // Choice between the register path and the peripheral path of one pin.
  function automatic logic pinMux(
    input logic sel,
    input logic alt,
    input logic own
  );
    pinMux = sel ? alt : own;
  endfunction

  // Peripheral inputs see the pin only while the pin is in peripheral mode.
  function automatic logic gateIn(
    input logic sel,
    input logic pin
  );
    gateIn = sel & pin;
  endfunction

  // A port requests an interrupt while any flag meets its enable bit.
  function automatic logic portIrq(
    input ppm_byte_t ifg,
    input ppm_byte_t ie
  );
    portIrq = |(ifg & ie);
  endfunction

  // Write decode; input registers and unmapped addresses leave the state untouched.
  function automatic ppm_state_t regWrite(
    input ppm_state_t             s,
    input logic [`PPM_ADDR_W-1:0] addr,
    input ppm_byte_t              data
  );
    regWrite = s;
    unique case (addr)
      `PPM_P1_OUT: regWrite.p1Out = data;
      `PPM_P1_DIR: regWrite.p1Dir = data;
      `PPM_P1_IFG: regWrite.p1Ifg = data;
      `PPM_P1_IES: regWrite.p1Ies = data;
      `PPM_P1_IE:  regWrite.p1Ie  = data;
      `PPM_P1_SEL: regWrite.p1Sel = data;
      `PPM_P2_OUT: regWrite.p2Out = data;
      `PPM_P2_DIR: regWrite.p2Dir = data;
      `PPM_P2_IFG: regWrite.p2Ifg = data;
      `PPM_P2_IES: regWrite.p2Ies = data;
      `PPM_P2_IE:  regWrite.p2Ie  = data;
      `PPM_P2_SEL: regWrite.p2Sel = data;
      `PPM_P3_OUT: regWrite.p3Out = data;
      `PPM_P3_DIR: regWrite.p3Dir = data;
      `PPM_P3_SEL: regWrite.p3Sel = data;
      default:     regWrite = s;
    endcase
  endfunction

  // Read-back decode; input registers show the synchronised pad levels.
  function automatic ppm_byte_t regRead(
    input ppm_state_t             s,
    input logic [`PPM_ADDR_W-1:0] addr,
    input ppm_byte_t              in1,
    input ppm_byte_t              in2,
    input ppm_byte_t              in3
  );
    unique case (addr)
      `PPM_P1_IN:  regRead = in1;
      `PPM_P1_OUT: regRead = s.p1Out;
      `PPM_P1_DIR: regRead = s.p1Dir;
      `PPM_P1_IFG: regRead = s.p1Ifg;
      `PPM_P1_IES: regRead = s.p1Ies;
      `PPM_P1_IE:  regRead = s.p1Ie;
      `PPM_P1_SEL: regRead = s.p1Sel;
      `PPM_P2_IN:  regRead = in2;
      `PPM_P2_OUT: regRead = s.p2Out;
      `PPM_P2_DIR: regRead = s.p2Dir;
      `PPM_P2_IFG: regRead = s.p2Ifg;
      `PPM_P2_IES: regRead = s.p2Ies;
      `PPM_P2_IE:  regRead = s.p2Ie;
      `PPM_P2_SEL: regRead = s.p2Sel;
      `PPM_P3_IN:  regRead = in3;
      `PPM_P3_OUT: regRead = s.p3Out;
      `PPM_P3_DIR: regRead = s.p3Dir;
      `PPM_P3_SEL: regRead = s.p3Sel;
      default:     regRead = 8'h00;
    endcase
  endfunction

  // All control, pad-drive and peripheral state of the block lives in one registered struct; the input synchronisers stand apart.
  ppm_state_t st_r;
  ppm_state_t st_nxt;
  ppm_byte_t  p1Alt;
  ppm_byte_t  p2Alt;
  ppm_byte_t  p3Alt;
  ppm_byte_t  p2Bonded;
  ppm_byte_t  p2In;
  ppm_byte_t  p3ModDir;
  ppm_byte_t  p1Edge;
  ppm_byte_t  p2Edge;
  ppm_byte_t  p1OutMux;
  ppm_byte_t  p1OeMux;
  ppm_byte_t  p2OutMux;
  ppm_byte_t  p2OeMux;
  ppm_byte_t  p3OutMux;
  ppm_byte_t  p3OeMux;

  // Port two bits that have a pad; the others exist only as register bits.
  localparam ppm_byte_t P2_PADS = `PPM_P2_PAD_MASK;

  // Peripheral outputs offered to port one in peripheral mode.
  assign p1Alt[0] = converterClock;
  assign p1Alt[1] = timerOutputUnit0;
  assign p1Alt[2] = timerOutputUnit1;
  assign p1Alt[3] = timerOutputUnit2;
  assign p1Alt[4] = subsystemClock;
  assign p1Alt[5] = timerOutputUnit0;
  assign p1Alt[6] = timerOutputUnit1;
  assign p1Alt[7] = timerOutputUnit2;

  // Peripheral outputs offered to port two; the unbonded bits carry a fixed low.
  assign p2Alt[0] = auxClock;
  assign p2Alt[1] = 1'b0;
  assign p2Alt[2] = timerOutputUnit0;
  assign p2Alt[3] = timerOutputUnit1;
  assign p2Alt[4] = timerOutputUnit2;
  assign p2Alt[5] = 1'b0;
  assign p2Alt[6] = 1'b0;
  assign p2Alt[7] = 1'b0;

  // Port three pin 0 offers a fixed low in peripheral mode.
  assign p3Alt[0]   = 1'b0;
  // The serial-unit pins above pin 0 are served elsewhere and carry low here.
  assign p3Alt[7:1] = 7'h00;

  // The serial unit never drives port-three pin 0, so its module direction is tied low.
  assign p3ModDir = st_r.p3Dir & ~(8'h01 << `PPM_P3_STE_BIT);

  // Unbonded bits read back as zero; a disconnected pin 5 reads as zero too.
  assign p2Bonded = p2Sync_r & P2_PADS;
  assign p2In     = rselSync_r ? (p2Bonded & ~(8'h01 << `PPM_P2_ROSC_BIT)) : p2Bonded;

  // Port one: edge detection and the register-or-peripheral choice for each pad.
  for (genvar i = 0; i < PORT_W; i++)
  begin : g_p1_pin
    assign p1Edge[i]   = pinEdge(p1Sync_r[i], st_r.p1InPrev[i], st_r.p1Ies[i]);
    assign p1OutMux[i] = pinMux(st_r.p1Sel[i], p1Alt[i], st_r.p1Out[i]);
    assign p1OeMux[i]  = pinMux(st_r.p1Sel[i], st_r.p1Dir[i], st_r.p1Dir[i]);
  end

  // Port two: edges on the unbonded bits are masked so only software sets their flags.
  for (genvar i = 0; i < PORT_W; i++)
  begin : g_p2_pin
    assign p2Edge[i]   = pinEdge(p2In[i], st_r.p2InPrev[i], st_r.p2Ies[i]) & P2_PADS[i];
    assign p2OutMux[i] = pinMux(st_r.p2Sel[i], p2Alt[i], st_r.p2Out[i]) & P2_PADS[i];
    assign p2OeMux[i]  = pinMux(st_r.p2Sel[i], st_r.p2Dir[i], st_r.p2Dir[i]) & P2_PADS[i];
  end

  // Port three has no interrupt logic, only the pad choice.
  for (genvar i = 0; i < PORT_W; i++)
  begin : g_p3_pin
    assign p3OutMux[i] = pinMux(st_r.p3Sel[i], p3Alt[i], st_r.p3Out[i]);
    assign p3OeMux[i]  = pinMux(st_r.p3Sel[i], p3ModDir[i], st_r.p3Dir[i]);
  end

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.p1InPrev = p1Sync_r;
    st_nxt.p2InPrev = p2In;
    if (regWr)
      st_nxt = regWrite(st_nxt, regAddr, regWrData);
    // Hardware set wins over a software clear in the same cycle.
    st_nxt.p1Ifg = st_nxt.p1Ifg | p1Edge;
    st_nxt.p2Ifg = st_nxt.p2Ifg | p2Edge;
    // Read data stand for one cycle after the strobe and are zero otherwise.
    st_nxt.rdData = regRd ? regRead(st_r, regAddr, p1Sync_r, p2In, p3Sync_r) : 8'h00;
    // Pad drive from the current control state, one edge behind a control write.
    st_nxt.padOut  = p1OutMux;
    st_nxt.padOe   = p1OeMux;
    st_nxt.pad2Out = p2OutMux;
    st_nxt.pad2Oe  = p2OeMux;
    // While the resistor select is set, pin 5 is cut off from its pad.
    if (rselSync_r)
    begin
      st_nxt.pad2Out[`PPM_P2_ROSC_BIT] = 1'b0;
      st_nxt.pad2Oe[`PPM_P2_ROSC_BIT]  = 1'b0;
    end
    st_nxt.pad3Out = p3OutMux;
    st_nxt.pad3Oe  = p3OeMux;
    // Peripheral inputs are fed only when the pin is in peripheral mode.
    st_nxt.tmrExtClk = gateIn(st_r.p1Sel[0], p1Sync_r[0]);
    st_nxt.capA[0]   = gateIn(st_r.p1Sel[1], p1Sync_r[1]);
    st_nxt.capA[1]   = gateIn(st_r.p1Sel[2], p1Sync_r[2]);
    st_nxt.capA[2]   = gateIn(st_r.p1Sel[3], p1Sync_r[3]);
    st_nxt.tmrAltClk = gateIn(st_r.p2Sel[1], p2In[1]);
    st_nxt.capB[0]   = gateIn(st_r.p2Sel[2], p2In[2]);
    st_nxt.capB[1]   = gateIn(st_r.p2Sel[3], p2In[3]);
    st_nxt.slaveTxEn = gateIn(st_r.p3Sel[0], p3Sync_r[0]);
    // Requests follow the flags as they stand after this edge, so a request rises with its flag.
    st_nxt.irq1 = portIrq(st_nxt.p1Ifg, st_nxt.p1Ie);
    st_nxt.irq2 = portIrq(st_nxt.p2Ifg, st_nxt.p2Ie);
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  // Every output is taken straight from the registered state.
  assign regRdData                 = st_r.rdData;
  assign p1PadOut                  = st_r.padOut;
  assign p1PadOe                   = st_r.padOe;
  assign p2PadOut                  = st_r.pad2Out;
  assign p2PadOe                   = st_r.pad2Oe;
  assign p3PadOut                  = st_r.pad3Out;
  assign p3PadOe                   = st_r.pad3Oe;
  assign timerExternalClock        = st_r.tmrExtClk;
  assign timerAlternateClock       = st_r.tmrAltClk;
  assign captureInputA             = st_r.capA;
  assign captureInputB             = st_r.capB;
  assign serialSlaveTransmitEnable = st_r.slaveTxEn;
  assign p1Irq                     = st_r.irq1;
  assign p2Irq                     = st_r.irq2;

endmodule

// File: tb/ppm_board_model.sv
// Board circuitry on the three ports: a pad reads its own drive, or the board level where undriven.
`timescale 1ns/100ps
module ppm_board_model (
  input  wire logic [7:0] p1PadOut,
  input  wire logic [7:0] p1PadOe,
  input  wire logic [7:0] p2PadOut,
  input  wire logic [7:0] p2PadOe,
  input  wire logic [7:0] p3PadOut,
  input  wire logic [7:0] p3PadOe,
  input  wire logic [7:0] board1,
  input  wire logic [7:0] board2,
  input  wire logic [7:0] board3,
  output logic      [7:0] p1PadIn,
  output logic      [7:0] p2PadIn,
  output logic      [7:0] p3PadIn
);
  assign p1PadIn = (p1PadOe & p1PadOut) | (~p1PadOe & board1);
  assign p2PadIn = (p2PadOe & p2PadOut) | (~p2PadOe & board2);
  assign p3PadIn = (p3PadOe & p3PadOut) | (~p3PadOe & board3);
endmodule

// File: tb/ppm_mux_asserts.sv
// Checker for pad routing and interrupt gating of the port pin function mux.
`timescale 1ns/100ps
`include "ppm_consts.svh"
module ppm_mux_asserts (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic       regWr,
  input wire logic [7:0] p1PadOut,
  input wire logic [7:0] p2PadOut,
  input wire logic [7:0] p2PadOe,
  input wire logic [7:0] p3PadOe,
  input wire logic       converterClock,
  input wire logic       subsystemClock,
  input wire logic       auxClock,
  input wire logic       timerOutputUnit0,
  input wire logic       p1Irq
);
  logic [7:0] s1, s2, s3, e1;
  // Shadows of the three select registers and the port one enable register, updated at the same edge as the design's own.
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
      {s1, s2, s3, e1} <= '0;
    else if (regWr)
      case (regAddr)
        `PPM_P1_SEL: s1 <= regWrData;
        `PPM_P2_SEL: s2 <= regWrData;
        `PPM_P3_SEL: s3 <= regWrData;
        `PPM_P1_IE:  e1 <= regWrData;
        default: ;
      endcase
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence en_off;
    e1 == 8'h00 ##1 e1 == 8'h00;
  endsequence
  a_p1_cvt_out: assert property ($past(s1[0]) |-> p1PadOut[0] == $past(converterClock)) else $error("p1 pin0");
  a_p1_tmr_out: assert property ($past(s1[1]) |-> p1PadOut[1] == $past(timerOutputUnit0)) else $error("p1 pin1");
  a_p1_sub_out: assert property ($past(s1[4]) |-> p1PadOut[4] == $past(subsystemClock)) else $error("p1 pin4");
  a_p2_aux_out: assert property ($past(s2[0]) |-> p2PadOut[0] == $past(auxClock)) else $error("p2 pin0");
  a_p2_low_out: assert property ($past(s2[1]) |-> !p2PadOut[1]) else $error("p2 pin1");
  a_p2_no_pads: assert property (p2PadOe[7:6] == 2'b00 && p2PadOut[7:6] == 2'b00) else $error("p2 pins 6 7");
  a_p3_in_only: assert property ($past(s3[0]) |-> !p3PadOe[0]) else $error("p3 pin0 drives");
  a_irq_gated: assert property (en_off |-> !p1Irq) else $error("p1 irq without enable");
endmodule
bind ppm_port_pin_function_mux ppm_mux_asserts i_chk (.*);

// File: tb/ppm_port_pin_function_mux_tb.sv
// Self-checking testbench of the port pin function mux.
`timescale 1ns/100ps
`include "ppm_consts.svh"
module ppm_port_pin_function_mux_tb;
  logic clk, rstn, regWr, regRd, converterClock, subsystemClock, auxClock, extResistorSelect;
  logic timerOutputUnit0, timerOutputUnit1, timerOutputUnit2, timerExternalClock, timerAlternateClock;
  logic serialSlaveTransmitEnable, p1Irq, p2Irq;
  logic [5:0] regAddr;
  logic [7:0] regWrData, regRdData, p1PadIn, p1PadOut, p1PadOe, p2PadIn, p2PadOut, p2PadOe;
  logic [7:0] p3PadIn, p3PadOut, p3PadOe, board1, board2, board3, a, b, ies;
  logic [2:0] captureInputA;
  logic [1:0] captureInputB;
  int n_errors, n_checks;
  ppm_port_pin_function_mux i_ppm_port_pin_function_mux (.*);
  ppm_board_model i_ppm_board_model (.*);
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] ad, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= ad;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rdc(input logic [5:0] ad, input logic [7:0] exp);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge clk);
    regRd <= 1'b0;
    #1 chk(regRdData, exp);
  endtask
  function automatic logic [7:0] flagExp(logic [7:0] x, y, e);
    return (e & x & ~y) | (~e & ~x & y);
  endfunction
  function automatic logic [7:0] p1Alt(logic c, s, u0, u1, u2);
    return {u2, u1, u0, s, u2, u1, u0, c};
  endfunction
  task automatic wrap_up;
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  initial
  begin
    {regWr, regRd, regAddr, regWrData, board1, board2, board3, extResistorSelect} = '0;
    {converterClock, subsystemClock, auxClock, timerOutputUnit0, timerOutputUnit1, timerOutputUnit2} = '0;
    rstn = 1'b0;
    void'($urandom(30));
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 1; i < 20; i++)
      if (i % 8 != 0 && i != 16) rdc(6'(i), 8'h00);
    repeat (4)
    begin
      a = $urandom;
      b = $urandom;
      wr(`PPM_P1_OUT, a);
      wr(`PPM_P1_DIR, b);
      repeat (2) @(posedge clk);
      #1 chk(p1PadOe, b);
      chk(p1PadOut & b, a & b);
    end
    wr(`PPM_P1_DIR, 8'h00);
    wr(`PPM_P1_SEL, 8'hFF);
    wr(`PPM_P2_SEL, 8'hFF);
    wr(`PPM_P3_SEL, 8'h01);
    wr(`PPM_P3_DIR, 8'h01);
    wr(`PPM_P3_OUT, 8'hFF);
    repeat (8)
    begin
      @(posedge clk);
      {converterClock, subsystemClock, auxClock, timerOutputUnit0, timerOutputUnit1, timerOutputUnit2} <= 6'($urandom);
      {board1, board2, board3} <= 24'($urandom);
      repeat (4) @(posedge clk);
      #1 chk(p1PadOut, p1Alt(converterClock, subsystemClock, timerOutputUnit0, timerOutputUnit1, timerOutputUnit2));
      chk(p2PadOut, {3'b000, timerOutputUnit2, timerOutputUnit1, timerOutputUnit0, 1'b0, auxClock});
      chk({timerAlternateClock, timerExternalClock, serialSlaveTransmitEnable, captureInputB, captureInputA},
          {board2[1], board1[0], board3[0], board2[3:2], board1[3:1]});
      chk(p3PadOe, 8'h00);
      chk(p3PadOut, 8'hFE);
    end
    wr(`PPM_P1_IE, 8'hFF);
    repeat (6)
    begin
      a = $urandom;
      b = $urandom;
      ies = $urandom;
      wr(`PPM_P1_IES, ies);
      board1 <= a;
      repeat (4) @(posedge clk);
      wr(`PPM_P1_IFG, 8'h00);
      board1 <= b;
      repeat (5) @(posedge clk);
      rdc(`PPM_P1_IFG, flagExp(a, b, ies));
      chk({7'h00, p1Irq}, {7'h00, flagExp(a, b, ies) != 8'h00});
    end
    wr(`PPM_P1_IFG, 8'hFF);
    wr(`PPM_P1_IE, 8'h00);
    repeat (2) @(posedge clk);
    #1 chk({7'h00, p1Irq}, 8'h00);
    wr(`PPM_P2_IE, 8'hC0);
    wr(`PPM_P2_IFG, 8'hC0);
    rdc(`PPM_P2_IFG, 8'hC0);
    chk({7'h00, p2Irq}, 8'h01);
    @(posedge clk);
    extResistorSelect <= 1'b1;
    board2 <= 8'h00;
    repeat (4) @(posedge clk);
    wr(`PPM_P2_IFG, 8'h00);
    board2 <= 8'h20;
    repeat (6) @(posedge clk);
    rdc(`PPM_P2_IFG, 8'h00);
    wrap_up();
  end
endmodule
